// File: mcs_card_model.sv
// behavioural memory card facing the host controller
`timescale 1ns/1ns
module mcs_card_model
(
   input wire logic clk,
   input wire logic [25:0] addr,
   input wire logic [15:0] d_out,
   input wire logic [15:0] d_oe_b,
   input wire logic ce1_b,
   input wire logic ce2_b,
   input wire logic oe_b,
   input wire logic we_b,
   input wire logic reg_b,
   input wire logic reset,
   input wire logic protect_switch,
   output logic [15:0] d_in,
   output logic busy_b,
   output logic protect,
   output logic wait_b,
   output logic bvd1_b,
   output logic bvd2_b
);
   logic [15:0] cmem [16]; // common words
   logic [7:0] amem [16]; // attribute even bytes
   logic [15:0] last = 16'h0000; // previous wire level
   logic [15:0] wlat; // data seen during write strobe
   logic [3:0] busy_cnt = 4'h0; // program time left
   logic we_q = 1'b1; // delayed write strobe
   wire [3:0] ix = addr[4:1];
   wire odd_lo = ce2_b && addr[0]; // odd byte moved to low lane
   wire rd = !oe_b && we_b && !reset;
   wire [15:0] w = reg_b ? cmem[ix] : {~last[15:8], amem[ix]};
   wire [15:0] c;
   assign c[15:8] = (rd && !ce2_b) ? w[15:8] : ~last[15:8];
   assign c[7:0] = (rd && !ce1_b) ? (odd_lo ? w[15:8] : w[7:0]) : ~last[7:0];
   assign d_in = (d_oe_b & c) | (~d_oe_b & d_out);
   assign busy_b = (busy_cnt == 4'h0);
   assign protect = protect_switch;
   assign wait_b = 1'b1;
   assign bvd1_b = 1'b1;
   assign bvd2_b = 1'b1;
   // store on the rising write strobe
   always @(posedge clk)
   begin
      last <= d_in;
      we_q <= we_b;
      if (!we_b)
         wlat <= d_in;
      if (busy_cnt != 4'h0)
         busy_cnt <= busy_cnt - 4'h1;
      if (we_b && !we_q && oe_b && !reset && !protect_switch)
      begin
         if (!reg_b)
         begin
            if (!ce1_b && !odd_lo)
               amem[ix] <= wlat[7:0];
         end
         else
         begin
            if (!ce1_b && odd_lo)
               cmem[ix][15:8] <= wlat[7:0];
            else if (!ce1_b)
               cmem[ix][7:0] <= wlat[7:0];
            if (!ce2_b)
               cmem[ix][15:8] <= wlat[15:8];
            busy_cnt <= 4'hF;
         end
      end
   end
endmodule : mcs_card_model

// File: mcs_defines.svh
// timing counts and field constants for the memory card host controller
`ifndef MCS_DEFINES_SVH
`define MCS_DEFINES_SVH
`define MCS_CLK_NS 100
`define MCS_WIDTH_WAIT_US 1000
`define MCS_WIDTH_WAIT_CYC ((`MCS_WIDTH_WAIT_US * 1000 + `MCS_CLK_NS - 1) / `MCS_CLK_NS)
`define MCS_STROBE_NS 300
`define MCS_STROBE_CYC ((`MCS_STROBE_NS + `MCS_CLK_NS - 1) / `MCS_CLK_NS)
`define MCS_SIZE_64M 1'h0
`define MCS_SIZE_128M 1'h1
`endif

// File: mcs_host.sv
// host socket controller driving a removable flash memory card
// Function
// - a0 selects byte only in x8
// - low enable even, high enable odd
// - word needs both enables, lanes split
// - write strobed by write enable, oe high
// - wait after width change before data
// - reset high powers card down
// - card present only if both detects low
// - data captured on write enable rise
`timescale 1ns/1ns
`include "mcs_defines.svh"
module mcs_host
   import mcs_pkg::*;
#(
   parameter int WIDTH_WAIT_CYC = `MCS_WIDTH_WAIT_CYC
)
(
   input wire logic SYS_CLK,
   input wire logic RST_B,
   input wire logic REQ_VALID,
   output logic REQ_READY,
   input wire logic REQ_WRITE,
   input wire logic REQ_ATTR,
   input wire logic [1:0] REQ_WIDTH,
   input wire logic [25:0] REQ_ADDR,
   input wire logic [15:0] REQ_WDATA,
   output logic RSP_VALID,
   output logic [15:0] RSP_RDATA,
   output logic RSP_ERROR,
   input wire logic CARD_RESET_REQ,
   output logic CARD_PRESENT,
   output logic CARD_BUSY,
   output logic CARD_PROTECTED,
   output logic [25:0] CARD_A,
   input wire logic [15:0] CARD_D_IN,
   output logic [15:0] CARD_D_OUT,
   output logic [15:0] CARD_D_OE_B,
   output logic CARD_CE1_B,
   output logic CARD_CE2_B,
   output logic CARD_OE_B,
   output logic CARD_WE_B,
   output logic CARD_REG_B,
   output logic CARD_RESET,
   input wire logic CARD_BUSY_B,
   input wire logic CARD_PROTECT,
   input wire logic CARD_CD1_B,
   input wire logic CARD_CD2_B,
   input wire logic CARD_WAIT_B,
   input wire logic CARD_BVD1_B,
   input wire logic CARD_BVD2_B
);
   localparam int STROBE_CYC = `MCS_STROBE_CYC;
   logic rst_meta_reg; // reset release stage one
   logic rst_b_reg; // synchronised reset
   logic [4:0] pin_meta_reg; // pin sync stage one
   logic [4:0] pin_reg; // pin sync stage two
   mcs_state_t state_reg; // sequencer state
   logic [19:0] cnt_reg; // phase and settle counter
   mcs_width_t last_width_reg; // width of previous access
   logic write_reg; // current access is a write
   logic attr_reg; // current access is attribute
   logic [15:0] wdata_reg; // write data held
   logic err_next; // refusal of a request
   mcs_width_t cur_width; // width of the access in flight, from the enables
   mcs_lane_if lane ();
   mcs_lane_dec u_dec (.lane(lane));
   // reset release through two flops
   always_ff @(posedge SYS_CLK or negedge RST_B)
   begin
      if (!RST_B)
      begin
         rst_meta_reg <= 1'b0;
         rst_b_reg <= 1'b0;
      end
      else
      begin
         rst_meta_reg <= 1'b1;
         rst_b_reg <= rst_meta_reg;
      end
   end
   // card status pins through two flops
   always_ff @(posedge SYS_CLK or negedge rst_b_reg)
   begin
      if (!rst_b_reg)
      begin
         pin_meta_reg <= 5'h1F;
         pin_reg <= 5'h1F;
      end
      else
      begin
         pin_meta_reg <= {CARD_PROTECT, CARD_BUSY_B, CARD_CD2_B, CARD_CD1_B, CARD_WAIT_B};
         pin_reg <= pin_meta_reg;
      end
   end
   // status to the user side
   assign CARD_PRESENT = ~pin_reg[1] & ~pin_reg[2];
   assign CARD_BUSY = ~pin_reg[3];
   assign CARD_PROTECTED = pin_reg[4];
   // card reset follows user request
   assign CARD_RESET = CARD_RESET_REQ;
   // request refused if absent, reset, or protected write
   always_comb
   begin
      err_next = !CARD_PRESENT || CARD_RESET_REQ || (REQ_WRITE && CARD_PROTECTED);
   end
   assign REQ_READY = (state_reg == MCS_IDLE);
   // lane decode inputs
   assign lane.width = mcs_width_t'(REQ_WIDTH == 2'h3 ? 2'h2 : REQ_WIDTH);
   assign lane.addr = REQ_ADDR;
   // width of the access on the pins; the user side may already move on
   always_comb
   begin
      if (!CARD_CE1_B && !CARD_CE2_B)
         cur_width = MCS_WORD;
      else if (CARD_CE1_B)
         cur_width = MCS_ODD;
      else
         cur_width = MCS_EVEN;
   end
   // sequencer; wait pin ignored since card never extends
   always_ff @(posedge SYS_CLK or negedge rst_b_reg)
   begin
      if (!rst_b_reg)
      begin
         state_reg <= MCS_IDLE;
         cnt_reg <= 20'h00000;
         last_width_reg <= MCS_WORD;
         write_reg <= 1'b0;
         attr_reg <= 1'b0;
         wdata_reg <= 16'h0000;
         CARD_A <= 26'h0000000;
         CARD_CE1_B <= 1'b1;
         CARD_CE2_B <= 1'b1;
         CARD_REG_B <= 1'b1;
         RSP_VALID <= 1'b0;
         RSP_ERROR <= 1'b0;
      end
      else
      begin
         RSP_VALID <= 1'b0;
         unique case (state_reg)
            MCS_IDLE:
            begin
               // both enables high: card in standby
               CARD_CE1_B <= 1'b1;
               CARD_CE2_B <= 1'b1;
               if (REQ_VALID && err_next)
               begin
                  RSP_VALID <= 1'b1;
                  RSP_ERROR <= 1'b1;
               end
               else if (REQ_VALID)
               begin
                  RSP_ERROR <= 1'b0;
                  write_reg <= REQ_WRITE;
                  attr_reg <= REQ_ATTR;
                  wdata_reg <= REQ_WDATA;
                  // device select bits pass straight onto A25..A1
                  CARD_A <= {REQ_ADDR[25:1], lane.a0};
                  CARD_REG_B <= ~REQ_ATTR;
                  CARD_CE1_B <= lane.ce1_n;
                  CARD_CE2_B <= lane.ce2_n;
                  cnt_reg <= 20'(STROBE_CYC - 1);
                  state_reg <= MCS_SETUP;
               end
            end
            MCS_SETUP:
            begin
               cnt_reg <= 20'(STROBE_CYC - 1);
               state_reg <= MCS_STROBE;
            end
            MCS_STROBE:
            begin
               if (cnt_reg == 20'h00000)
               begin
                  state_reg <= MCS_HOLD;
               end
               else
               begin
                  cnt_reg <= cnt_reg - 20'h00001;
               end
            end
            MCS_HOLD:
            begin
               // strobe just rose; card latches on the next edge, as this state ends
               CARD_CE1_B <= 1'b1;
               CARD_CE2_B <= 1'b1;
               CARD_REG_B <= 1'b1;
               // compare against the access just done, not the live request
               if (!write_reg && (last_width_reg != cur_width))
               begin
                  cnt_reg <= 20'(WIDTH_WAIT_CYC);
                  state_reg <= MCS_SETTLE;
               end
               else
               begin
                  RSP_VALID <= 1'b1;
                  state_reg <= MCS_IDLE;
               end
               last_width_reg <= cur_width;
            end
            MCS_SETTLE:
            begin
               // width changed: hold off read result
               if (cnt_reg == 20'h00000)
               begin
                  RSP_VALID <= 1'b1;
                  state_reg <= MCS_IDLE;
               end
               else
               begin
                  cnt_reg <= cnt_reg - 20'h00001;
               end
            end
            default:
            begin
               state_reg <= MCS_IDLE;
            end
         endcase
      end
   end
   // read capture at end of strobe, lanes steered to user
   always_ff @(posedge SYS_CLK or negedge rst_b_reg)
   begin
      if (!rst_b_reg)
      begin
         RSP_RDATA <= 16'h0000;
      end
      else if (state_reg == MCS_STROBE && cnt_reg == 20'h00000 && !write_reg)
      begin
         if (!CARD_CE1_B && !CARD_CE2_B)
            RSP_RDATA <= {attr_reg ? 8'h00 : CARD_D_IN[15:8], CARD_D_IN[7:0]};
         else if (!CARD_CE2_B)
            RSP_RDATA <= {8'h00, attr_reg ? 8'h00 : CARD_D_IN[15:8]};
         else
            RSP_RDATA <= {8'h00, (attr_reg && CARD_A[0]) ? 8'h00 : CARD_D_IN[7:0]};
      end
   end
   // strobes: only a read or a write, never both
   always_ff @(posedge SYS_CLK or negedge rst_b_reg)
   begin
      if (!rst_b_reg)
      begin
         CARD_OE_B <= 1'b1;
         CARD_WE_B <= 1'b1;
         CARD_D_OUT <= 16'h0000;
         CARD_D_OE_B <= 16'hFFFF;
      end
      else if (state_reg == MCS_SETUP)
      begin
         CARD_OE_B <= write_reg;
         CARD_WE_B <= ~write_reg;
         if (write_reg)
         begin
            // odd byte alone via low enable sits on D7..0
            CARD_D_OUT <= (!CARD_CE1_B && CARD_CE2_B && CARD_A[0]) ? {8'h00, wdata_reg[15:8]}
               : (CARD_CE1_B ? {wdata_reg[15:8], 8'h00} : wdata_reg);
            CARD_D_OE_B <= {{8{CARD_CE2_B}}, {8{CARD_CE1_B}}};
         end
      end
      else if (state_reg == MCS_STROBE && cnt_reg == 20'h00000)
      begin
         // rising write enable latches data
         CARD_OE_B <= 1'b1;
         CARD_WE_B <= 1'b1;
      end
      else if (state_reg != MCS_STROBE)
      begin
         CARD_OE_B <= 1'b1;
         CARD_WE_B <= 1'b1;
         CARD_D_OE_B <= 16'hFFFF;
      end
   end
endmodule : mcs_host

// File: mcs_host_properties.sv
// bus protocol checks for the memory card host controller
`timescale 1ns/1ns
module mcs_host_chk
(
   input wire logic SYS_CLK,
   input wire logic RST_B,
   input wire logic REQ_VALID,
   input wire logic REQ_READY,
   input wire logic REQ_WRITE,
   input wire logic REQ_ATTR,
   input wire logic [1:0] REQ_WIDTH,
   input wire logic [25:0] REQ_ADDR,
   input wire logic [25:0] CARD_A,
   input wire logic RSP_VALID,
   input wire logic RSP_ERROR,
   input wire logic CARD_PROTECTED,
   input wire logic CARD_RESET_REQ,
   input wire logic CARD_RESET,
   input wire logic [15:0] CARD_D_OE_B,
   input wire logic CARD_CE1_B,
   input wire logic CARD_CE2_B,
   input wire logic CARD_OE_B,
   input wire logic CARD_WE_B,
   input wire logic CARD_REG_B
);
   default clocking @(posedge SYS_CLK); endclocking
   default disable iff (!RST_B);
   logic [1:0] width_reg; // width of the access in flight
   logic attr_reg; // region of the access in flight
   logic [25:0] addr_reg; // address of the access in flight
   wire take = REQ_VALID && REQ_READY;
   wire strobe = !CARD_OE_B || !CARD_WE_B;
   // remember what was asked at the take edge
   always_ff @(posedge SYS_CLK)
   begin
      if (take)
      begin
         width_reg <= REQ_WIDTH;
         attr_reg <= REQ_ATTR;
         addr_reg <= REQ_ADDR;
      end
   end
   sequence write_pulse_s;
      !CARD_WE_B [*3] ##1 CARD_WE_B;
   endsequence
   AST_STROBE_LEN: assert property ($fell(CARD_WE_B) |-> write_pulse_s)
      else $error("write strobe length wrong");
   AST_NO_BOTH: assert property (!(!CARD_OE_B && !CARD_WE_B))
      else $error("read and write strobes together");
   AST_SELECTED: assert property (strobe |-> !(CARD_CE1_B && CARD_CE2_B))
      else $error("strobe while card deselected");
   AST_HOST_FLOAT: assert property (!CARD_OE_B |-> &CARD_D_OE_B)
      else $error("host drives data during read");
   AST_LANES: assert property (strobe |-> {CARD_CE2_B, CARD_CE1_B} ==
      (width_reg[1] ? 2'h0 : (width_reg[0] ? 2'h1 : 2'h2)))
      else $error("card enables do not match width");
   AST_ADDR: assert property (strobe |-> CARD_A[25:1] == addr_reg[25:1])
      else $error("card address differs from request");
   AST_A0: assert property (strobe && width_reg == 2'h0 |-> CARD_A[0] == addr_reg[0])
      else $error("byte select bit differs from request");
   AST_REGION: assert property (strobe |-> CARD_REG_B == !attr_reg)
      else $error("region select wrong");
   AST_RESET: assert property (CARD_RESET == CARD_RESET_REQ)
      else $error("card reset not following request");
   AST_PROT: assert property (take && REQ_WRITE && CARD_PROTECTED |=> RSP_VALID && RSP_ERROR)
      else $error("protected write not refused");
   AST_WDATA: assert property (!CARD_WE_B && !CARD_CE1_B |-> CARD_D_OE_B[7:0] == 8'h00)
      else $error("low lane not driven in write");
endmodule : mcs_host_chk
bind mcs_host mcs_host_chk chk_u (.SYS_CLK(SYS_CLK), .RST_B(RST_B), .REQ_VALID(REQ_VALID),
   .REQ_READY(REQ_READY), .REQ_WRITE(REQ_WRITE), .REQ_ATTR(REQ_ATTR), .REQ_WIDTH(REQ_WIDTH),
   .REQ_ADDR(REQ_ADDR), .CARD_A(CARD_A),
   .RSP_VALID(RSP_VALID), .RSP_ERROR(RSP_ERROR), .CARD_PROTECTED(CARD_PROTECTED),
   .CARD_RESET_REQ(CARD_RESET_REQ), .CARD_RESET(CARD_RESET), .CARD_D_OE_B(CARD_D_OE_B),
   .CARD_CE1_B(CARD_CE1_B), .CARD_CE2_B(CARD_CE2_B), .CARD_OE_B(CARD_OE_B),
   .CARD_WE_B(CARD_WE_B), .CARD_REG_B(CARD_REG_B));

// File: mcs_lane_dec.sv
// card enable and address bit 0 decode from the requested width
`timescale 1ns/1ns
module mcs_lane_dec
   import mcs_pkg::*;
(
   mcs_lane_if.dec lane
);
   // enables for each width
   always_comb
   begin
      lane.a0 = 1'b0;
      lane.ce1_n = 1'b1;
      lane.ce2_n = 1'b1;
      unique case (lane.width)
         MCS_EVEN:
         begin
            // low enable alone, a0 picks byte
            lane.ce1_n = 1'b0;
            lane.a0 = lane.addr[0];
         end
         MCS_ODD:
         begin
            lane.ce2_n = 1'b0;
            lane.a0 = 1'b1;
         end
         MCS_WORD:
         begin
            // both enables, a0 left low
            lane.ce1_n = 1'b0;
            lane.ce2_n = 1'b0;
         end
         default:
         begin
            lane.ce1_n = 1'b1;
         end
      endcase
   end
endmodule : mcs_lane_dec

// File: mcs_lane_if.sv
// lane steering signals between the sequencer and the lane decoder
`timescale 1ns/1ns
interface mcs_lane_if;
   import mcs_pkg::*;
   mcs_width_t width; // requested width
   logic [25:0] addr; // byte address
   logic ce1_n; // low byte enable
   logic ce2_n; // high byte enable
   logic a0; // address bit 0
   modport seq (output width, output addr, input ce1_n, input ce2_n, input a0);
   modport dec (input width, input addr, output ce1_n, output ce2_n, output a0);
endinterface : mcs_lane_if

// File: mcs_pkg.sv
// types shared by the memory card host controller
package mcs_pkg;
   typedef enum logic [1:0] {MCS_EVEN = 2'h0, MCS_ODD = 2'h1, MCS_WORD = 2'h2} mcs_width_t;
   typedef enum logic [4:0] {
      MCS_IDLE = 5'h01,
      MCS_SETUP = 5'h02,
      MCS_STROBE = 5'h04,
      MCS_HOLD = 5'h08,
      MCS_SETTLE = 5'h10
   } mcs_state_t;
endpackage : mcs_pkg

// File: memory_card_bus_steering_test.sv
// self-checking bench for the memory card host controller
`timescale 1ns/1ns
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin error_cnt++; \
   $display("CHECK FAILED %s expected %h seen %h", nm, e, g); end end
module memory_card_bus_steering_test;
   logic SYS_CLK = 0, RST_B = 0, REQ_VALID = 0, REQ_WRITE = 0, REQ_ATTR = 0;
   logic CARD_RESET_REQ = 0, CARD_CD1_B = 0, CARD_CD2_B = 0, protect_sw = 0;
   logic [1:0] REQ_WIDTH = 2'h0;
   logic [25:0] REQ_ADDR = 26'h0;
   logic [15:0] REQ_WDATA = 16'h0, wd, wb;
   wire REQ_READY, RSP_VALID, RSP_ERROR, CARD_PRESENT, CARD_BUSY, CARD_PROTECTED;
   wire CARD_CE1_B, CARD_CE2_B, CARD_OE_B, CARD_WE_B, CARD_REG_B, CARD_RESET;
   wire CARD_BUSY_B, CARD_PROTECT, CARD_WAIT_B, CARD_BVD1_B, CARD_BVD2_B;
   wire [15:0] RSP_RDATA, CARD_D_IN, CARD_D_OUT, CARD_D_OE_B;
   wire [25:0] CARD_A;
   logic [17:0] exp_q [$]; // {check data, error, data}
   logic [17:0] e;
   logic [25:0] hi; // random upper address bits
   int error_cnt = 0, checks_done = 0, seed = 81;
   mcs_host #(.WIDTH_WAIT_CYC(4)) dut_u (.*);
   mcs_card_model card_u (.clk(SYS_CLK), .addr(CARD_A), .d_out(CARD_D_OUT),
      .d_oe_b(CARD_D_OE_B), .ce1_b(CARD_CE1_B), .ce2_b(CARD_CE2_B), .oe_b(CARD_OE_B),
      .we_b(CARD_WE_B), .reg_b(CARD_REG_B), .reset(CARD_RESET), .protect_switch(protect_sw),
      .d_in(CARD_D_IN), .busy_b(CARD_BUSY_B), .protect(CARD_PROTECT), .wait_b(CARD_WAIT_B),
      .bvd1_b(CARD_BVD1_B), .bvd2_b(CARD_BVD2_B));
   always #50 SYS_CLK = ~SYS_CLK;
   task test_done;
      if (error_cnt == 0 && checks_done > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : test_done
   // one request: hold until taken, then wait for the answer
   task automatic xfer(input logic wr, at, input logic [1:0] wdt, input logic [25:0] ad,
      input logic [15:0] dat, input logic [17:0] ex);
      int n;
      exp_q.push_back(ex);
      REQ_VALID = 1;
      REQ_WRITE = wr;
      REQ_ATTR = at;
      REQ_WIDTH = wdt;
      REQ_ADDR = ad;
      REQ_WDATA = dat;
      n = 0;
      // ready read off the edge, where it already holds for the next edge
      while (REQ_READY !== 1'b1 && n < 50)
      begin
         @(posedge SYS_CLK);
         #1;
         n++;
      end
      if (n >= 50)
         error_cnt++;
      @(posedge SYS_CLK);
      #1 REQ_VALID = 0;
      n = 0;
      // a refusal answers at once, so look before the next edge
      while (RSP_VALID !== 1'b1 && n < 60)
      begin
         @(posedge SYS_CLK);
         #1;
         n++;
      end
      if (n >= 60)
         error_cnt++;
      @(posedge SYS_CLK);
      #1;
   endtask : xfer
   // answers are compared against the oldest note, mid-cycle where settled
   always @(negedge SYS_CLK)
   begin
      if (RSP_VALID === 1'b1)
      begin
         e = exp_q.pop_front();
         `CHK("rsp_error", e[16], RSP_ERROR)
         if (e[17])
            `CHK("rsp_rdata", e[15:0], RSP_RDATA)
      end
   end
   initial
   begin
      #200000;
      error_cnt++;
      test_done;
   end
   initial
   begin
      repeat (8) @(posedge SYS_CLK);
      #1 RST_B = 1;
      repeat (6) @(posedge SYS_CLK);
      #1 wd = 16'($random(seed));
      wb = 16'($random(seed));
      hi = 26'($random(seed)) & 26'h3FFFFE0;
      xfer(1, 0, 2'h2, hi | 26'h2, wd, 18'h0);
      xfer(0, 0, 2'h2, hi | 26'h2, 16'h0, {2'h2, wd});
      xfer(0, 0, 2'h0, 26'h2, 16'h0, {2'h2, 8'h00, wd[7:0]});
      xfer(0, 0, 2'h0, hi | 26'h3, 16'h0, {2'h2, 8'h00, wd[15:8]});
      xfer(0, 0, 2'h1, 26'h2, 16'h0, {2'h2, 8'h00, wd[15:8]});
      xfer(1, 0, 2'h0, 26'h3, {wb[7:0], 8'h00}, 18'h0);
      repeat (2) @(posedge SYS_CLK);
      #1 `CHK("card_busy", 1'b1, CARD_BUSY)
      xfer(0, 0, 2'h2, 26'h2, 16'h0, {2'h2, wb[7:0], wd[7:0]});
      xfer(1, 1, 2'h2, 26'h4, wd, 18'h0);
      xfer(1, 1, 2'h0, 26'h5, {wb[7:0], 8'h00}, 18'h0);
      xfer(0, 1, 2'h2, 26'h4, 16'h0, {2'h2, 8'h00, wd[7:0]});
      protect_sw = 1;
      repeat (20) @(posedge SYS_CLK);
      #1 `CHK("card_busy", 1'b0, CARD_BUSY)
      xfer(1, 0, 2'h2, 26'h2, ~wd, 18'h10000);
      xfer(0, 0, 2'h2, 26'h2, 16'h0, {2'h2, wb[7:0], wd[7:0]});
      protect_sw = 0;
      CARD_RESET_REQ = 1;
      #1 `CHK("card_reset", 1'b1, CARD_RESET)
      xfer(0, 0, 2'h2, 26'h2, 16'h0, 18'h10000);
      CARD_RESET_REQ = 0;
      repeat (4) @(posedge SYS_CLK);
      #1 xfer(0, 0, 2'h2, 26'h2, 16'h0, {2'h2, wb[7:0], wd[7:0]});
      CARD_CD2_B = 1;
      repeat (5) @(posedge SYS_CLK);
      #1 `CHK("card_present", 1'b0, CARD_PRESENT)
      xfer(0, 0, 2'h2, 26'h2, 16'h0, 18'h10000);
      test_done;
   end
endmodule : memory_card_bus_steering_test
